// *** tmz_pkg.sv ***
package tmz_pkg;

    // Option bits that steer the counter, grouped as one word.
    typedef struct packed {
        logic       count_source_select;
        logic       source_edge_select;
        logic       prescaler_assign;
        logic [2:0] prescale_ratio_field;
    } tmz_opt_t;

    // Software access to the counter value.
    typedef struct packed {
        logic       wr;
        logic [7:0] wdata;
    } tmz_wr_t;

    localparam int        CNT_W          = 8;
    localparam int        PRE_W          = 8;
    localparam logic [7:0] CNT_MAX       = 8'hFF;
    localparam logic [7:0] CNT_RST       = 8'h00;
    localparam logic [7:0] PRE_RST       = 8'h00;

    // Quarter-rate phase clock: Q1..Q4 are phase values 0..3.
    localparam logic [1:0] PH_RST        = 2'h0;
    localparam logic [1:0] PH_Q2         = 2'h1;
    localparam logic [1:0] PH_Q4         = 2'h3;

    // Increment hold-off after a counter write, in instruction cycles.
    localparam logic [1:0] INHIBIT_INSTR = 2'h2;

    // Oscillator period and the synchroniser delay window in periods.
    localparam int        TOSC_NS        = 40;
    localparam int        CLK_MHZ        = 25;
    localparam int        SYNC_MIN_NS    = 3 * TOSC_NS;
    localparam int        SYNC_MAX_NS    = 7 * TOSC_NS;
    localparam int        SYNC_MIN_CYC   = (SYNC_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int        SYNC_MAX_CYC   = (SYNC_MAX_NS * CLK_MHZ) / 1000;

endpackage : tmz_pkg

// *** tmz_timer.sv ***
`timescale 1ns/1ps
module tmz_timer
    import tmz_pkg::*;
(
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             arst_n,
    // Configuration
    input  wire tmz_opt_t         opt,
    input  wire logic             overflow_irq_enable,
    input  wire logic             sleep,
    // Counter access
    input  wire tmz_wr_t          count_wr,
    output logic [CNT_W-1:0]      timer_count_reg,
    // Interrupt flag
    input  wire logic             flag_clear,
    output logic                  overflow_flag,
    output logic                  overflow_irq,
    // Watchdog side
    input  wire logic             wdt_tick,
    input  wire logic             watchdog_clear_instr,
    output logic                  wdt_post_tick,
    // External count pin
    input  wire logic             ext_count_pin,
    // Instruction cycle marker
    output logic                  instr_tick
);

    // Phase counter and instruction-cycle strobe.
    logic [1:0]       phase;
    logic [1:0]       next_phase;

    // Prescaler and its output edge detector.
    logic [PRE_W-1:0] pre;
    logic [PRE_W-1:0] next_pre;
    logic             pre_out_d;
    logic             next_pre_out_d;
    logic             next_wdt_post_tick;

    // Count pin edge detector and Q2/Q4 synchroniser.
    logic             pin_d;
    logic             next_pin_d;
    logic             samp_q2;
    logic             next_samp_q2;
    logic             samp_q4;
    logic             next_samp_q4;

    // Counter, hold-off and flag.
    logic [CNT_W-1:0] next_count;
    logic [1:0]       inhibit;
    logic [1:0]       next_inhibit;
    logic             next_flag;

    // Combinational helpers.
    logic             pin_lvl;
    logic             pin_rise;
    logic             src_event;
    logic             pre_to_tmr;
    logic             pre_event;
    logic             pre_clear;
    logic             pre_out;
    logic             pre_rise;
    logic             sync_lvl;
    logic             inc_timer;
    logic             inc_counter;
    logic             inc;
    logic             overflow;

    // Selects one bit of the prescaler by the ratio field.
    function automatic logic pre_tap(input logic [PRE_W-1:0] p,
                                     input logic [2:0] r);
        pre_tap = p[r];
    endfunction : pre_tap

    // ---------------- Phase clock ----------------
    always_comb begin
        next_phase = phase + 2'h1;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase <= PH_RST;
        end else begin
            phase <= next_phase;
        end
    end

    assign instr_tick = (phase == PH_Q4);

    // ---------------- Source and prescaler ----------------
    always_comb begin
        // Edge select inverts the pin so only rising edges matter below.
        pin_lvl    = ext_count_pin ^ opt.source_edge_select;
        pin_rise   = pin_lvl & ~pin_d;
        src_event  = opt.count_source_select ? pin_rise : instr_tick;
        pre_to_tmr = ~opt.prescaler_assign;
        // The prescaler never counts both sources at once.
        pre_event  = pre_to_tmr ? (src_event & ~sleep) : wdt_tick;
        pre_clear  = pre_to_tmr ? count_wr.wr : watchdog_clear_instr;
        pre_out    = pre_tap(pre, opt.prescale_ratio_field);
        pre_rise   = pre_out & ~pre_out_d;
        next_pin_d = pin_lvl;
        next_pre_out_d = pre_out;
        next_wdt_post_tick = opt.prescaler_assign & pre_rise;
        if (pre_clear) begin
            next_pre = PRE_RST;
        end else if (pre_event) begin
            next_pre = pre + 8'h01;
        end else begin
            next_pre = pre;
        end
    end

    // The prescaler has no read or write path; only clears reach it.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pre           <= PRE_RST;
            pre_out_d     <= 1'b0;
            pin_d         <= 1'b0;
            wdt_post_tick <= 1'b0;
        end else begin
            pre           <= next_pre;
            pre_out_d     <= next_pre_out_d;
            pin_d         <= next_pin_d;
            wdt_post_tick <= next_wdt_post_tick;
        end
    end

    // ---------------- Q2/Q4 synchroniser ----------------
    // Sampling after the prescaler lets a divided pin run above the instruction rate, up to half the clock.
    always_comb begin
        sync_lvl     = pre_to_tmr ? pre_out : pin_lvl;
        next_samp_q2 = samp_q2;
        next_samp_q4 = samp_q4;
        if (phase == PH_Q2) begin
            next_samp_q2 = sync_lvl;
        end
        if (phase == PH_Q4) begin
            next_samp_q4 = samp_q2;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            samp_q2 <= 1'b0;
            samp_q4 <= 1'b0;
        end else begin
            samp_q2 <= next_samp_q2;
            samp_q4 <= next_samp_q4;
        end
    end

    // ---------------- Counter ----------------
    always_comb begin
        // Timer mode uses the internal strobe, divided when prescaled.
        inc_timer   = pre_to_tmr ? pre_rise : instr_tick;
        inc_counter = (phase == PH_Q4) & samp_q2 & ~samp_q4;
        inc         = (opt.count_source_select ? inc_counter : inc_timer)
                      & ~sleep & (inhibit == 2'h0);
        overflow    = inc & (timer_count_reg == CNT_MAX);
        next_inhibit = inhibit;
        if (count_wr.wr) begin
            next_inhibit = INHIBIT_INSTR;
        end else if (instr_tick && inhibit != 2'h0) begin
            next_inhibit = inhibit - 2'h1;
        end
        if (count_wr.wr) begin
            next_count = count_wr.wdata;
        end else if (inc) begin
            next_count = timer_count_reg + 8'h01;
        end else begin
            next_count = timer_count_reg;
        end
        // A set in the same cycle as a clear wins.
        next_flag = overflow | (overflow_flag & ~flag_clear);
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            timer_count_reg <= CNT_RST;
            inhibit         <= 2'h0;
            overflow_flag   <= 1'b0;
        end else begin
            timer_count_reg <= next_count;
            inhibit         <= next_inhibit;
            overflow_flag   <= next_flag;
        end
    end

    assign overflow_irq = overflow_flag & overflow_irq_enable;

    // ---------------- Assertions ----------------

    property p_wrap;
        @(posedge sys_clk) disable iff (!arst_n)
        (inc && !count_wr.wr && timer_count_reg == CNT_MAX)
            |=> (timer_count_reg == CNT_RST);
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap to zero");

    property p_timer_step;
        @(posedge sys_clk) disable iff (!arst_n)
        (!opt.count_source_select && opt.prescaler_assign && instr_tick && !sleep
         && inhibit == 2'h0 && !count_wr.wr)
            |=> (timer_count_reg == $past(timer_count_reg) + 8'h01);
    endproperty
    a_timer_step: assert property (p_timer_step) else $error("timer missed a tick");

    property p_hold_off;
        @(posedge sys_clk) disable iff (!arst_n)
        (count_wr.wr && !sleep) |=> (timer_count_reg == $past(count_wr.wdata))
            ##1 (inhibit != 2'h0)[*4];
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("write hold-off too short");

    property p_no_inc_held;
        @(posedge sys_clk) disable iff (!arst_n)
        (inhibit != 2'h0 && !count_wr.wr) |=> $stable(timer_count_reg);
    endproperty
    a_no_inc_held: assert property (p_no_inc_held) else $error("count moved in hold-off");

    property p_sleep_stop;
        @(posedge sys_clk) disable iff (!arst_n)
        (sleep && !count_wr.wr) |=> $stable(timer_count_reg);
    endproperty
    a_sleep_stop: assert property (p_sleep_stop) else $error("count moved in sleep");

    property p_flag_set;
        @(posedge sys_clk) disable iff (!arst_n)
        overflow |=> overflow_flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("overflow not flagged");

    property p_flag_sticky;
        @(posedge sys_clk) disable iff (!arst_n)
        (overflow_flag && !flag_clear) |=> overflow_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

    property p_irq_mask;
        @(posedge sys_clk) disable iff (!arst_n)
        overflow_irq == (overflow_flag && overflow_irq_enable);
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq not masked");

    property p_pre_clr;
        @(posedge sys_clk) disable iff (!arst_n)
        (!opt.prescaler_assign && count_wr.wr) |=> (pre == PRE_RST);
    endproperty
    a_pre_clr: assert property (p_pre_clr) else $error("prescaler not cleared");

    property p_wdt_clr;
        @(posedge sys_clk) disable iff (!arst_n)
        (opt.prescaler_assign && watchdog_clear_instr) |=> (pre == PRE_RST);
    endproperty
    a_wdt_clr: assert property (p_wdt_clr) else $error("wdt clear missed");

    property p_sync_delay;
        @(posedge sys_clk) disable iff (!arst_n)
        $rose(sync_lvl) ##1 sync_lvl[*3] |=> samp_q2;
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("sync delay too long");

    property p_sync_min;
        @(posedge sys_clk) disable iff (!arst_n)
        $rose(samp_q4) |-> $past(samp_q2, 2);
    endproperty
    a_sync_min: assert property (p_sync_min) else $error("sync stage skipped");

    property p_wdt_only;
        @(posedge sys_clk) disable iff (!arst_n)
        !opt.prescaler_assign |=> !wdt_post_tick;
    endproperty
    a_wdt_only: assert property (p_wdt_only) else $error("prescaler served both");

endmodule : tmz_timer

// *** tmz_pin_src.sv ***
`timescale 1ns/1ps
module tmz_pin_src (
    // Clock
    input  wire logic sys_clk,
    // Count pin
    output logic      ext_count_pin
);
    initial ext_count_pin = 1'b0;

    // The pin moves only after a falling edge and then holds for whole cycles.
    task automatic step(input logic lvl, input int hold);
        @(negedge sys_clk);
        ext_count_pin = lvl;
        repeat (hold - 1) @(negedge sys_clk);
    endtask : step

    task automatic pulses(input int n, input int hold);
        repeat (n) begin
            step(1'b1, hold);
            step(1'b0, hold);
        end
    endtask : pulses
endmodule : tmz_pin_src

// *** tmz_timer_tb.sv ***
`timescale 1ns/1ps
module tmz_timer_tb;
    import tmz_pkg::*;
    logic       sys_clk;
    logic       arst_n;
    tmz_opt_t   opt;
    logic       overflow_irq_enable;
    logic       sleep;
    tmz_wr_t    count_wr;
    logic [7:0] timer_count_reg;
    logic       flag_clear;
    logic       overflow_flag;
    logic       overflow_irq;
    logic       wdt_tick;
    logic       watchdog_clear_instr;
    logic       wdt_post_tick;
    logic       ext_count_pin;
    logic       instr_tick;
    int         failures;
    int         n_tests;
    int         cycles;
    int         wdt_seen;

    tmz_timer i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .opt(opt),
        .overflow_irq_enable(overflow_irq_enable), .sleep(sleep), .count_wr(count_wr),
        .timer_count_reg(timer_count_reg), .flag_clear(flag_clear),
        .overflow_flag(overflow_flag), .overflow_irq(overflow_irq), .wdt_tick(wdt_tick),
        .watchdog_clear_instr(watchdog_clear_instr), .wdt_post_tick(wdt_post_tick),
        .ext_count_pin(ext_count_pin), .instr_tick(instr_tick));
    tmz_pin_src i_src (.sys_clk(sys_clk), .ext_count_pin(ext_count_pin));

    always #20 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        cycles++;
        if (wdt_post_tick === 1'b1) wdt_seen++;
        if (cycles == 20000) begin
            failures++;
            test_done();
        end
    end

    task automatic test_done;
        if (failures == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    // Every stimulus task starts and ends at a falling edge, where inputs change.
    task automatic tick(input int n);
        repeat (n) begin
            while (instr_tick !== 1'b1) @(negedge sys_clk);
            @(negedge sys_clk);
        end
    endtask : tick

    task automatic wr(input logic [7:0] v);
        count_wr = '{1'b1, v};
        @(negedge sys_clk);
        count_wr.wr = 1'b0;
    endtask : wr

    task automatic wdt(input int n);
        repeat (n) begin
            wdt_tick = 1'b1;
            @(negedge sys_clk);
            wdt_tick = 1'b0;
            @(negedge sys_clk);
        end
    endtask : wdt

    task automatic clr_wdt;
        watchdog_clear_instr = 1'b1;
        @(negedge sys_clk);
        watchdog_clear_instr = 1'b0;
    endtask : clr_wdt

    initial begin
        sys_clk              = 1'b0;
        arst_n               = 1'b0;
        opt                  = '{1'b0, 1'b0, 1'b1, 3'h0};
        overflow_irq_enable  = 1'b0;
        sleep                = 1'b0;
        count_wr             = '0;
        flag_clear           = 1'b0;
        wdt_tick             = 1'b0;
        watchdog_clear_instr = 1'b0;
        failures             = 0;
        n_tests              = 0;
        cycles               = 0;
        wdt_seen             = 0;
        repeat (8) @(negedge sys_clk);
        check(timer_count_reg, 8'h00);
        check(overflow_flag, 8'h00);
        arst_n = 1'b1;
        wr(8'hFC);
        tick(2);
        check(timer_count_reg, 8'hFC);
        tick(1);
        check(timer_count_reg, 8'hFD);
        // The strobe stands only in the last clock of each instruction cycle.
        repeat (2) @(negedge sys_clk);
        check(instr_tick, 8'h00);
        @(negedge sys_clk);
        check(instr_tick, 8'h01);
        tick(2);
        check(overflow_flag, 8'h00);
        tick(1);
        check(timer_count_reg, 8'h00);
        check(overflow_flag, 8'h01);
        check(overflow_irq, 8'h00);
        overflow_irq_enable = 1'b1;
        @(negedge sys_clk);
        check(overflow_irq, 8'h01);
        tick(3);
        check(overflow_flag, 8'h01);
        flag_clear = 1'b1;
        @(negedge sys_clk);
        flag_clear = 1'b0;
        check(overflow_flag, 8'h00);
        check(overflow_irq, 8'h00);
        wr(8'h30);
        tick(3);
        sleep = 1'b1;
        tick(10);
        check(timer_count_reg, 8'h31);
        sleep = 1'b0;
        tick(1);
        check(timer_count_reg, 8'h32);
        // The first tap rise after a clear is swallowed by the hold-off only at 1:2.
        opt.prescaler_assign = 1'b0;
        for (int r = 0; r < 8; r++) begin
            opt.prescale_ratio_field = r[2:0];
            wr(8'h00);
            tick(2 * (2 << r) + 2);
            check(timer_count_reg, 8'h02);
        end
        wr(8'h00);
        tick(100);
        check(timer_count_reg, 8'h00);
        wr(8'h20);
        tick(100);
        check(timer_count_reg, 8'h20);
        tick(40);
        check(timer_count_reg, 8'h21);
        opt = '{1'b0, 1'b0, 1'b1, 3'h2};
        clr_wdt();
        wdt_seen = 0;
        wdt(16);
        check(wdt_seen[7:0], 8'h02);
        wdt(5);
        clr_wdt();
        wdt(4);
        // The post tick is counted one clock after it rises.
        @(negedge sys_clk);
        check(wdt_seen[7:0], 8'h04);
        opt = '{1'b1, 1'b0, 1'b1, 3'h0};
        wr(8'h00);
        tick(3);
        i_src.step(1'b1, 8);
        check(timer_count_reg, 8'h01);
        i_src.step(1'b0, 8);
        check(timer_count_reg, 8'h01);
        i_src.step(1'b1, 8);
        opt.source_edge_select = 1'b1;
        // The flipped level must reach a Q2 sample before the pin moves again.
        repeat (4) @(negedge sys_clk);
        i_src.step(1'b0, 2);
        check(timer_count_reg, 8'h02);
        repeat (6) @(negedge sys_clk);
        check(timer_count_reg, 8'h03);
        i_src.step(1'b1, 8);
        i_src.pulses(3, 4);
        repeat (8) @(negedge sys_clk);
        check(timer_count_reg, 8'h06);
        opt.prescaler_assign = 1'b0;
        opt.prescale_ratio_field = 3'h1;
        wr(8'h00);
        tick(3);
        i_src.pulses(16, 1);
        repeat (10) @(negedge sys_clk);
        check(timer_count_reg, 8'h04);
        test_done();
    end
endmodule : tmz_timer_tb
